// ### swd_pkg.sv
// Package for the two-stage system watchdog: widths, timing, stage codes and port groups.
package swd_pkg;

  // ----------------------------------------------------------------
  // Counter and timing
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W           = 35;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 35'h0_0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE    = 35'h0_0000_0001;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned TICK_US         = 1000;
  localparam int unsigned TICK_CYC        = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TICK_W          = 16;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [TICK_W-1:0] TICK_ZERO = 16'h0000;
  localparam int unsigned MAX_TIMEOUT_S   = 600;
  localparam int unsigned RST_CYC         = 16;
  localparam int unsigned RST_W           = 5;
  localparam logic [RST_W-1:0] RST_LOAD   = RST_W'(RST_CYC);
  localparam logic [RST_W-1:0] RST_ZERO   = 5'h00;

  // ----------------------------------------------------------------
  // Interrupt type selection and stage codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SWD_IRQ_REQ = 2'b00,
    SWD_IRQ_MGMT = 2'b01,
    SWD_IRQ_CTRL = 2'b10,
    SWD_IRQ_OFF = 2'b11
  } swd_irq_sel_e;

  typedef enum logic [1:0] {
    SWD_IDLE   = 2'b00,
    SWD_STAGE1 = 2'b01,
    SWD_STAGE2 = 2'b10
  } swd_state_e;

  // Configuration from the surrounding control logic.
  typedef struct packed {
    logic               enable;
    logic [CNT_W-1:0]   preload1;
    logic [CNT_W-1:0]   preload2;
    swd_irq_sel_e       irq_sel;
  } swd_cfg_s;

  // First-stage interrupt pulses, one per type.
  typedef struct packed {
    logic irq_req;
    logic system_management_interrupt;
    logic system_control_interrupt;
  } swd_irq_s;

endpackage

// ### swd_tick.sv
// Millisecond enable divider for the system watchdog.
`timescale 1ns/10ps
module swd_tick (
  input  wire logic core_clk, // Core clock.
  input  wire logic sys_rst,  // Asynchronous reset, active high.
  input  wire logic run,      // Divider runs while high.
  output logic      tick      // One-cycle pulse every millisecond.
);
  import swd_pkg::*;

  logic [TICK_W-1:0] div_q;
  logic [TICK_W-1:0] div_d;
  wire               wrap = (div_q == TICK_LAST);

  assign div_d = (!run || wrap) ? TICK_ZERO : div_q + TICK_W'(1);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= TICK_ZERO;
      tick  <= 1'b0;
    end else begin
      div_q <= div_d;
      tick  <= run && wrap;
    end
  end
endmodule

// ### swd_core.sv
// Two-stage system watchdog: down-counter, stage control, interrupt and reset outputs.
// Notes on behaviour
// - Unrefreshed timer resets the whole board.
// - Timeout spans one millisecond to ten minutes.
// - First expiry raises request, management or control interrupt, unless type is off.
// - 35-bit down-counter loaded from first preload.
// - Counting starts only once enabled; stage one.
// - Stage one reaching zero raises internal interrupt.
// - Then load second preload; count stage two.
// - Stage two expiry asserts hard system reset.
`timescale 1ns/10ps
module swd_core (
  input  wire logic              core_clk,   // Core clock, 40 MHz.
  input  wire logic              sys_rst,    // Asynchronous reset, active high.
  input  wire swd_pkg::swd_cfg_s cfg,        // Enable, preloads and interrupt type.
  input  wire logic              reload,     // Software refresh strobe.
  output swd_pkg::swd_irq_s      irq,        // First-stage interrupt pulses.
  output logic                   sys_reset,  // Hard system reset, active high.
  output logic                   stage2,     // High while in the second stage.
  output logic [34:0]            count       // Current counter value.
);
  import swd_pkg::*;

  // ----------------------------------------------------------------
  // Millisecond time base
  // ----------------------------------------------------------------
  // One count is one millisecond, so a 35-bit counter easily covers
  // ten minutes; the finest setting of one count gives one millisecond.
  logic tick;
  wire  running;

  swd_tick u_tick (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .run      (running),
    .tick     (tick)
  );

  // ----------------------------------------------------------------
  // Stage control and counter
  // ----------------------------------------------------------------
  swd_state_e       state_q;
  swd_state_e       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [RST_W-1:0] rst_cnt_q;
  logic [RST_W-1:0] rst_cnt_d;
  logic             expire1;
  logic             expire2;

  assign running = (state_q != SWD_IDLE);
  // A preload of zero still expires after one tick, never instantly.
  wire   at_end  = tick && (cnt_q <= CNT_ONE);
  assign expire1 = (state_q == SWD_STAGE1) && at_end && !reload;
  assign expire2 = (state_q == SWD_STAGE2) && at_end && !reload;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      SWD_IDLE: begin
        cnt_d = cfg.preload1;
        if (cfg.enable) begin
          state_d = SWD_STAGE1;
        end
      end
      SWD_STAGE1, SWD_STAGE2: begin
        if (!cfg.enable) begin
          state_d = SWD_IDLE;
          cnt_d   = cfg.preload1;
        end else if (reload) begin
          state_d = SWD_STAGE1;
          cnt_d   = cfg.preload1;
        end else if (expire1) begin
          state_d = SWD_STAGE2;
          cnt_d   = cfg.preload2;
        end else if (expire2) begin
          state_d = SWD_STAGE1;
          cnt_d   = cfg.preload1;
        end else if (tick) begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      default: begin
        state_d = SWD_IDLE;
        cnt_d   = cfg.preload1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Reset stretch
  // ----------------------------------------------------------------
  // The reset pulse is stretched so the board reset sees a clean width.
  // A second expiry inside the pulse restarts the full width.
  assign rst_cnt_d = expire2 ? RST_LOAD :
                     (rst_cnt_q != RST_ZERO) ? rst_cnt_q - RST_W'(1) : RST_ZERO;

  // ----------------------------------------------------------------
  // Interrupt type decode
  // ----------------------------------------------------------------
  wire irq_req_d  = expire1 && (cfg.irq_sel == SWD_IRQ_REQ);
  wire irq_mgmt_d = expire1 && (cfg.irq_sel == SWD_IRQ_MGMT);
  wire irq_ctrl_d = expire1 && (cfg.irq_sel == SWD_IRQ_CTRL);

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q   <= SWD_IDLE;
      cnt_q     <= CNT_ZERO;
      rst_cnt_q <= RST_ZERO;
      irq       <= '0;
      sys_reset <= 1'b0;
      stage2    <= 1'b0;
      count     <= CNT_ZERO;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      rst_cnt_q <= rst_cnt_d;
      irq       <= '{irq_req: irq_req_d,
                     system_management_interrupt: irq_mgmt_d,
                     system_control_interrupt: irq_ctrl_d};
      sys_reset <= (rst_cnt_d != RST_ZERO);
      stage2    <= (state_d == SWD_STAGE2);
      count     <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Tick spacing monitor
  // ----------------------------------------------------------------
  // Counts cycles since the last tick so that the checks can hold the
  // tick spacing to one millisecond without a long repetition. Only the
  // checks below read it; it has no effect on the outputs.
  logic [TICK_W-1:0] gap_q;
  logic [TICK_W-1:0] gap_d;

  assign gap_d = (tick || !running) ? TICK_ZERO : gap_q + TICK_W'(1);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_q <= TICK_ZERO;
    end else begin
      gap_q <= gap_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // The interrupt lines are one-hot and last one cycle, so any stray
  // level on them outside a first-stage expiry is an error.
  irq_fire_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    expire1 && cfg.irq_sel == SWD_IRQ_MGMT |=> irq.system_management_interrupt)
    else $error("First-stage expiry gave no management interrupt.");
  stage_two_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    expire1 && cfg.enable |=> stage2 && count == $past(cfg.preload2))
    else $error("Second stage did not load second preload.");
  reset_on_expire_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    expire2 |=> sys_reset [*8])
    else $error("Second-stage expiry gave no held reset.");
  reload_stage1_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reload && running && cfg.enable |=> !stage2 && count == $past(cfg.preload1)
      && irq == '0)
    else $error("Reload did not return to stage one.");
  idle_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_q == SWD_IDLE && !cfg.enable |=> count == $past(cfg.preload1) && !stage2)
    else $error("Counter moved while not enabled.");
  count_step_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    running && cfg.enable && tick && !reload && cnt_q > CNT_ONE
      |=> cnt_q == $past(cnt_q) - CNT_ONE)
    else $error("Counter did not step down on a tick.");
  tick_rate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick && running |=> !tick [*8])
    else $error("Time base ticks too fast.");
  no_reset_stage1_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_q == SWD_STAGE1 && rst_cnt_q == RST_ZERO |=> !sys_reset)
    else $error("Reset asserted during stage one.");
  irq_req_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    expire1 && cfg.irq_sel == SWD_IRQ_REQ |=> irq.irq_req)
    else $error("First-stage expiry gave no interrupt request.");
  irq_ctrl_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    expire1 && cfg.irq_sel == SWD_IRQ_CTRL |=> irq.system_control_interrupt)
    else $error("First-stage expiry gave no control interrupt.");
  irq_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    expire1 && cfg.irq_sel == SWD_IRQ_OFF |=> irq == '0)
    else $error("Disabled interrupt type still raised a line.");
  irq_single_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !expire1 |=> irq == '0)
    else $error("Interrupt line raised without a first-stage expiry.");
  reload_quiet_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reload && running && rst_cnt_q == RST_ZERO |=> !sys_reset && irq == '0)
    else $error("Reload still gave an interrupt or a reset.");
  stage_back_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    expire2 && cfg.enable |=> !stage2 && count == $past(cfg.preload1))
    else $error("Second-stage expiry did not restart stage one.");
  reset_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    expire2 |=> rst_cnt_q == RST_LOAD)
    else $error("Reset stretch did not load its full width.");
  disable_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    running && !cfg.enable |=> !stage2 && count == $past(cfg.preload1))
    else $error("Disable did not return the counter to idle.");
  stage2_rise_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(stage2) |-> $past(expire1))
    else $error("Second stage entered without a first-stage expiry.");
  tick_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !running |=> !tick)
    else $error("Time base ticked while idle.");
  count_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    running && cfg.enable && !tick && !reload |=> count == $past(count))
    else $error("Counter moved between ticks.");
  tick_slow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    running |-> gap_q <= TICK_W'(TICK_CYC))
    else $error("Time base ticks too slowly.");
  tick_fast_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick |-> gap_q >= TICK_LAST)
    else $error("Time base tick came early.");
endmodule

// ### two_stage_watchdog_timer_tb.sv
// Self-checking testbench for the two-stage system watchdog core.
`timescale 1ns/10ps
module two_stage_watchdog_timer_tb;
  import swd_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  swd_cfg_s    cfg;
  logic        reload;
  swd_irq_s    irq;
  logic        sys_reset;
  logic        stage2;
  logic [34:0] count;
  logic [34:0] pre1;
  int          bad_count = 0;
  int          n_checks  = 0;
  int          cyc       = 0;
  int          seed      = 96;
  int          n;

  always #12.5 core_clk = ~core_clk;

  swd_core dut_u (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .cfg       (cfg),
    .reload    (reload),
    .irq       (irq),
    .sys_reset (sys_reset),
    .stage2    (stage2),
    .count     (count)
  );

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  // One pulse line per interrupt type; the disabled type raises none.
  function automatic swd_irq_s exp_irq(input swd_irq_sel_e s);
    exp_irq = {s == SWD_IRQ_REQ, s == SWD_IRQ_MGMT, s == SWD_IRQ_CTRL};
  endfunction

  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Each stage lasts one millisecond tick here, so the run is about two ticks long.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cfg    = '0;
    reload = 1'b0;
    repeat (8) @(negedge core_clk);
    check({irq, sys_reset, stage2}, 35'h0);
    sys_rst = 1'b0;
    pre1 = 35'({$random(seed), $random(seed)});
    cfg.preload1 = pre1;
    cfg.preload2 = 35'h0_0000_0001;
    cfg.enable   = 1'b1;
    repeat (2) @(negedge core_clk);
    check(count, pre1);
    reload = 1'b1;
    @(negedge core_clk);
    reload = 1'b0;
    @(negedge core_clk);
    check(count, pre1);
    check(stage2, 1'b0);
    cfg.enable = 1'b0;
    repeat (2) @(negedge core_clk);
    check(count, pre1);
    $display("test load and reload done");
    cfg.preload1 = 35'h0_0000_0001;
    cfg.irq_sel  = SWD_IRQ_MGMT;
    cfg.enable   = 1'b1;
    n = 0;
    while (stage2 !== 1'b1 && n < 41000) begin
      @(negedge core_clk);
      n++;
    end
    check(irq, exp_irq(SWD_IRQ_MGMT));
    check(count, cfg.preload2);
    check(sys_reset, 1'b0);
    @(negedge core_clk);
    check(irq, 3'h0);
    $display("test first stage expiry done");
    n = 0;
    while (stage2 === 1'b1 && n < 41000) begin
      @(negedge core_clk);
      n++;
    end
    check(count, cfg.preload1);
    n = 0;
    while (sys_reset === 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    check(n, RST_CYC);
    $display("test second stage reset done");
    print_verdict();
  end
endmodule
